/* File: rtl/sps_pkg.sv */
// Purpose: shared constants and types of the song playback / sync control block
// Assumes: 125 MHz system clock, APB register access
// Notes:   all offsets are byte addresses of aligned 32-bit words
package sps_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ  = 125000;
	localparam int END_MS   = 2000;                // song-end display time
	localparam int END_CYC  = END_MS * CLK_KHZ;    // longest time, exact
	localparam int HOLD_MS  = 500;                 // hold before rapid stepping
	localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
	localparam int RPT_MS   = 80;                  // rapid step period
	localparam int RPT_CYC  = RPT_MS * CLK_KHZ;
	localparam int TICKS_PER_BEAT = 96;            // internal position resolution

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;     // [0] tape fetch/verify busy
	localparam logic [7:0] OFS_LAST   = 8'h04;     // [9:0] last step of song
	localparam logic [7:0] OFS_PLEN   = 8'h08;     // [15:0] ticks per step
	localparam logic [7:0] OFS_TDIV   = 8'h0C;     // [19:0] cycles per local tick
	localparam logic [7:0] OFS_REPEAT = 8'h10;     // [9:0] from [19:10] to [27:20] count
	localparam logic [7:0] OFS_STATUS = 8'h14;     // read-only state
	localparam logic [9:0]  LAST_RST  = 10'h010;
	localparam logic [15:0] PLEN_RST  = 16'h0180;  // one 4/4 bar
	localparam logic [19:0] TDIV_RST  = 20'h9EF21; // 120 beats per minute
	localparam int ST_SRC_POS  = 4;                // status field positions
	localparam int ST_PPB_POS  = 6;
	localparam int ST_STEP_POS = 8;
	localparam int ST_SONG_POS = 18;
	localparam int ST_RUN_POS  = 22;

	// ----------------------------------------------------------------
	// key lines, index into the synchronised key vector
	// ----------------------------------------------------------------
	localparam int K_START = 0;
	localparam int K_HALT  = 1;
	localparam int K_LIB   = 2;
	localparam int K_INC   = 3;
	localparam int K_DEC   = 4;
	localparam int K_SYNC  = 5;
	localparam int K_TAPE  = 6;
	localparam int K_SEC   = 7;
	localparam int K_STORE = 8;
	localparam int K_FETCH = 9;
	localparam int K_NUM   = 10;
	localparam int K_TAPEIN = 11;
	localparam int K_MIDI  = 12;
	localparam int NLINES  = 17;                   // 13 lines plus 4 digit bits

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_SONG_SEL, ST_PAT_SEL, ST_PLAY, ST_HALT, ST_END,
		ST_SYNC_SRC, ST_PPB, ST_TAPE_MENU, ST_TAPE_XFER
	} sps_state_t;
	typedef enum logic [1:0] {SRC_LOCAL, SRC_PULSE, SRC_MIDI} sps_src_t;
	typedef enum logic [1:0] {PPB_24, PPB_48, PPB_96} sps_ppb_t;

endpackage : sps_pkg

/* File: rtl/sps_sync3.sv */
// Purpose: three-stage input synchroniser with debounced level and rise pulse
// Assumes: inputs asynchronous to clk_in
// Notes:   a change counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module sps_sync3 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level_out,
	output logic      [WIDTH-1:0] rise_out
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] lvl;
		logic [WIDTH-1:0] rise;
	} sps_sync_t;

	sps_sync_t q_r;
	sps_sync_t q_nxt;

	// stage one feeds stage two only
	always_comb begin
		q_nxt      = q_r;
		q_nxt.s1   = async_in;
		q_nxt.s2   = q_r.s1;
		q_nxt.s3   = q_r.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (q_r.s2[i] == q_r.s3[i]) begin
				q_nxt.lvl[i] = q_r.s2[i];
			end
		end
		q_nxt.rise = q_nxt.lvl & ~q_r.lvl;
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign level_out = q_r.lvl;
	assign rise_out  = q_r.rise;
endmodule : sps_sync3
`default_nettype wire

/* File: rtl/sps_ctrl.sv */
// Purpose: song playback control with timing source selection and tape menu
// Assumes: keys, tape input and midi clock tick arrive asynchronously
// Notes:   song data, tape transfer engine and midi byte decoding live outside
//
// What this block does
// - start on song screen begins playback, lamp
// - step counter starts at 001, advances
// - repeats jump step number, never displayed
// - after last step, end shown ~2s
// - halt-resume stops, then resumes exactly
// - start while halted restarts from beginning
// - library key while halted returns to selection
// - number key while halted selects that song
// - inc/dec step 001..last while halted, hold repeats
// - resume after stepping starts displayed step
// - secondary functions need secondary key held
// - sync menu from selection, halt screens
// - dec cycles local, pulse, midi, local
// - sync/inc accepts local or midi source
// - midi source takes timing from midi clock
// - pulse source takes timing from tape input
// - pulse source refused during tape fetch/verify
// - pulses per beat selectable 24, 48, 96
// - sync key leaves pulse rate screen
// - local pulse clock driven on tape output
// - tape or dec key leaves tape menu
// - no tape data until store/fetch chosen
// - tape data stored only with local source
`timescale 1ns/10ps
`default_nettype none
module sps_ctrl #(
	parameter int END_CYC  = sps_pkg::END_CYC,
	parameter int HOLD_CYC = sps_pkg::HOLD_CYC,
	parameter int RPT_CYC  = sps_pkg::RPT_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// front panel and link pins
	input  wire logic [10:0] keys_in,
	input  wire logic [3:0]  digit_in,
	input  wire logic        tape_in,
	input  wire logic        midi_tick_in,
	output logic             tape_out,
	output logic             tape_xfer_en_out,
	output logic             tape_fetch_out,
	output logic             tape_store_en_out,
	output logic             run_lamp_out,
	output logic [3:0]       disp_state_out,
	output logic [3:0]       disp_song_out,
	output logic [9:0]       disp_step_out,
	output logic             step_tick_out
);
	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	if (END_CYC < 1 || END_CYC >= 2**28 || HOLD_CYC < 1 || HOLD_CYC >= 2**28
	    || RPT_CYC < 1 || RPT_CYC >= 2**28) begin : g_bad
		$error("sps_ctrl: timer count out of 28-bit range");
	end

	typedef struct packed {
		sps_pkg::sps_state_t st;
		logic        ret_pat;
		logic [3:0]  song;
		logic [9:0]  step;
		logic [15:0] pos;
		logic [7:0]  rep_left;
		logic        stepped;
		sps_pkg::sps_src_t src;
		sps_pkg::sps_src_t shown_src;
		sps_pkg::sps_ppb_t ppb;
		logic        fetch_op;
		logic [19:0] tdiv_cnt;
		logic [1:0]  tick_ph;
		logic        tape_o;
		logic        step_tick;
		logic [27:0] tmr;
		logic [27:0] hold_cnt;
		logic        busy;
		logic [9:0]  last;
		logic [15:0] plen;
		logic [19:0] tdiv;
		logic [27:0] rep;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        lamp;
		logic        xfer;
		logic        store;
	} sps_ctrl_t;

	sps_ctrl_t q_r;
	sps_ctrl_t q_nxt;

	logic [sps_pkg::NLINES-1:0] lvl;
	logic [sps_pkg::NLINES-1:0] rise;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	sps_sync3 #(.WIDTH(sps_pkg::NLINES)) u_sync (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.async_in   ({digit_in, midi_tick_in, tape_in, keys_in}),
		.level_out  (lvl),
		.rise_out   (rise)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic       sec;
		logic       ltick;
		logic [2:0] inc;
		logic       step_up;
		logic       step_dn;
		logic [16:0] sum;
		logic [7:0]  a;
		q_nxt   = q_r;
		// secondary functions only with the secondary key held
		// secondary key gating
		sec     = lvl[sps_pkg::K_SEC];
		ltick   = 1'b0;
		inc     = 3'd0;
		step_up = 1'b0;
		step_dn = 1'b0;
		sum     = '0;
		a       = {paddr_in[7:2], 2'b00};
		q_nxt.step_tick = 1'b0;

		// local tempo divider, one tick per 1/96 beat
		if (q_r.tdiv_cnt >= q_r.tdiv - 20'd1) begin
			q_nxt.tdiv_cnt = '0;
			ltick          = 1'b1;
			q_nxt.tick_ph  = q_r.tick_ph + 2'd1;
		end else begin
			q_nxt.tdiv_cnt = q_r.tdiv_cnt + 20'd1;
		end
		// local pulse clock out, 24 per beat
		q_nxt.tape_o = (q_r.src == sps_pkg::SRC_LOCAL) && (q_r.st != sps_pkg::ST_TAPE_XFER)
		               && !q_nxt.tick_ph[1];

		// position increment per timing event, in 1/96 beat units
		case (q_r.src)
			// midi clock is 24 per beat
			sps_pkg::SRC_MIDI: inc = rise[sps_pkg::K_MIDI] ? 3'd4 : 3'd0;
			sps_pkg::SRC_PULSE: begin
				if (rise[sps_pkg::K_TAPEIN] && !q_r.busy) begin
					case (q_r.ppb)
						sps_pkg::PPB_24: inc = 3'd4;
						sps_pkg::PPB_48: inc = 3'd2;
						default:         inc = 3'd1;
					endcase
				end
			end
			default: inc = ltick ? 3'd1 : 3'd0;
		endcase

		// held inc/dec keys repeat after a delay
		// rapid stepping on hold
		if (rise[sps_pkg::K_INC] || rise[sps_pkg::K_DEC]) begin
			q_nxt.hold_cnt = '0;
			step_up        = rise[sps_pkg::K_INC];
			step_dn        = rise[sps_pkg::K_DEC];
		end else if (lvl[sps_pkg::K_INC] || lvl[sps_pkg::K_DEC]) begin
			if (q_r.hold_cnt >= 28'(HOLD_CYC + RPT_CYC - 1)) begin
				q_nxt.hold_cnt = 28'(HOLD_CYC);
				step_up        = lvl[sps_pkg::K_INC];
				step_dn        = lvl[sps_pkg::K_DEC];
			end else begin
				q_nxt.hold_cnt = q_r.hold_cnt + 28'd1;
			end
		end

		// main screen machine
		case (q_r.st)
			sps_pkg::ST_SONG_SEL, sps_pkg::ST_PAT_SEL: begin
				if (rise[sps_pkg::K_NUM]) begin
					q_nxt.song = lvl[16:13];
				end
				if (rise[sps_pkg::K_LIB] && !sec) begin
					q_nxt.st = (q_r.st == sps_pkg::ST_SONG_SEL) ? sps_pkg::ST_PAT_SEL
					                                             : sps_pkg::ST_SONG_SEL;
				end else if (rise[sps_pkg::K_START] && q_r.st == sps_pkg::ST_SONG_SEL) begin
					q_nxt.st       = sps_pkg::ST_PLAY;
					q_nxt.step     = 10'd1;
					q_nxt.pos      = '0;
					q_nxt.rep_left = q_r.rep[27:20];
				end
			end
			sps_pkg::ST_PLAY: begin
				if (rise[sps_pkg::K_HALT]) begin
					q_nxt.st      = sps_pkg::ST_HALT;
					q_nxt.stepped = 1'b0;
				end else if (inc != 3'd0) begin
					sum = {1'b0, q_r.pos} + 17'(inc);
					if (sum >= {1'b0, q_r.plen}) begin
						q_nxt.pos       = '0;
						q_nxt.step_tick = 1'b1;
						// repeat jumps move the step number
						if (q_r.step == q_r.rep[9:0] && q_r.rep_left != 8'd0) begin
							q_nxt.step     = q_r.rep[19:10];
							q_nxt.rep_left = q_r.rep_left - 8'd1;
						end else if (q_r.step >= q_r.last) begin
							q_nxt.st  = sps_pkg::ST_END;
							q_nxt.tmr = '0;
						end else begin
							q_nxt.step = q_r.step + 10'd1;
						end
					end else begin
						q_nxt.pos = sum[15:0];
					end
				end
			end
			sps_pkg::ST_END: begin
				// back to song screen after ~2s
				if (q_r.tmr >= 28'(END_CYC - 1)) begin
					q_nxt.st = sps_pkg::ST_SONG_SEL;
				end else begin
					q_nxt.tmr = q_r.tmr + 28'd1;
				end
			end
			sps_pkg::ST_HALT: begin
				if (rise[sps_pkg::K_START]) begin
					q_nxt.st       = sps_pkg::ST_PLAY;
					q_nxt.step     = 10'd1;
					q_nxt.pos      = '0;
					q_nxt.rep_left = q_r.rep[27:20];
				end else if (rise[sps_pkg::K_HALT]) begin
					q_nxt.st = sps_pkg::ST_PLAY;
					if (q_r.stepped) begin
						q_nxt.pos = '0;
					end
				end else if (rise[sps_pkg::K_LIB] && !sec) begin
					q_nxt.st = sps_pkg::ST_SONG_SEL;
				end else if (rise[sps_pkg::K_NUM]) begin
					q_nxt.st   = sps_pkg::ST_SONG_SEL;
					q_nxt.song = lvl[16:13];
				end else if (step_up && q_r.step < q_r.last) begin
					q_nxt.step    = q_r.step + 10'd1;
					q_nxt.stepped = 1'b1;
				end else if (step_dn && q_r.step > 10'd1) begin
					q_nxt.step    = q_r.step - 10'd1;
					q_nxt.stepped = 1'b1;
				end
			end
			sps_pkg::ST_SYNC_SRC: begin
				if (rise[sps_pkg::K_DEC]) begin
					case (q_r.shown_src)
						sps_pkg::SRC_LOCAL: q_nxt.shown_src = sps_pkg::SRC_PULSE;
						sps_pkg::SRC_PULSE: q_nxt.shown_src = sps_pkg::SRC_MIDI;
						default:            q_nxt.shown_src = sps_pkg::SRC_LOCAL;
					endcase
				end else if (rise[sps_pkg::K_SYNC] || rise[sps_pkg::K_INC]) begin
					if (q_r.shown_src == sps_pkg::SRC_PULSE) begin
						if (!q_r.busy) begin
							q_nxt.st  = sps_pkg::ST_PPB;
							q_nxt.src = sps_pkg::SRC_PULSE;
						end
					end else begin
						q_nxt.src = q_r.shown_src;
						q_nxt.st  = q_r.ret_pat ? sps_pkg::ST_PAT_SEL : sps_pkg::ST_SONG_SEL;
					end
				end
			end
			sps_pkg::ST_PPB: begin
				if (rise[sps_pkg::K_SYNC]) begin
					q_nxt.st = q_r.ret_pat ? sps_pkg::ST_PAT_SEL : sps_pkg::ST_SONG_SEL;
				end else if (rise[sps_pkg::K_INC]) begin
					case (q_r.ppb)
						sps_pkg::PPB_24: q_nxt.ppb = sps_pkg::PPB_48;
						sps_pkg::PPB_48: q_nxt.ppb = sps_pkg::PPB_96;
						default:         q_nxt.ppb = sps_pkg::PPB_24;
					endcase
				end else if (rise[sps_pkg::K_DEC]) begin
					case (q_r.ppb)
						sps_pkg::PPB_96: q_nxt.ppb = sps_pkg::PPB_48;
						sps_pkg::PPB_48: q_nxt.ppb = sps_pkg::PPB_24;
						default:         q_nxt.ppb = sps_pkg::PPB_96;
					endcase
				end
			end
			sps_pkg::ST_TAPE_MENU: begin
				if ((rise[sps_pkg::K_TAPE] && !sec) || rise[sps_pkg::K_DEC]) begin
					q_nxt.st = q_r.ret_pat ? sps_pkg::ST_PAT_SEL : sps_pkg::ST_SONG_SEL;
				end else if (rise[sps_pkg::K_STORE] || rise[sps_pkg::K_FETCH]) begin
					q_nxt.st       = sps_pkg::ST_TAPE_XFER;
					q_nxt.fetch_op = rise[sps_pkg::K_FETCH];
				end
			end
			sps_pkg::ST_TAPE_XFER: begin
				// tape key hands control back to the menu
				if (rise[sps_pkg::K_TAPE] && !sec) begin
					q_nxt.st = sps_pkg::ST_TAPE_MENU;
				end
			end
			default: q_nxt.st = sps_pkg::ST_SONG_SEL;
		endcase

		// secondary entry, only from selection or halted screens
		// sync menu entry points
		if (sec && (q_r.st == sps_pkg::ST_SONG_SEL || q_r.st == sps_pkg::ST_PAT_SEL
		            || q_r.st == sps_pkg::ST_HALT)) begin
			if (rise[sps_pkg::K_SYNC]) begin
				q_nxt.st        = sps_pkg::ST_SYNC_SRC;
				q_nxt.shown_src = q_r.src;
				q_nxt.ret_pat   = (q_r.st == sps_pkg::ST_PAT_SEL);
			end else if (rise[sps_pkg::K_TAPE]) begin
				q_nxt.st      = sps_pkg::ST_TAPE_MENU;
				q_nxt.ret_pat = (q_r.st == sps_pkg::ST_PAT_SEL);
			end
		end

		// panel flags kept in flops, in step with the state
		q_nxt.lamp  = (q_nxt.st == sps_pkg::ST_PLAY);
		q_nxt.xfer  = (q_nxt.st == sps_pkg::ST_TAPE_XFER);
		q_nxt.store = q_nxt.xfer && q_nxt.fetch_op && (q_nxt.src == sps_pkg::SRC_LOCAL);

		// apb: answer one cycle after setup, write at the pready edge
		q_nxt.pready = psel_in && !penable_in && !q_r.pready;
		if (psel_in && !penable_in && !q_r.pready) begin
			q_nxt.pslverr = 1'b0;
			q_nxt.prdata  = '0;
			case (a)
				sps_pkg::OFS_CTRL:   q_nxt.prdata[0]     = q_r.busy;
				sps_pkg::OFS_LAST:   q_nxt.prdata[9:0]   = q_r.last;
				sps_pkg::OFS_PLEN:   q_nxt.prdata[15:0]  = q_r.plen;
				sps_pkg::OFS_TDIV:   q_nxt.prdata[19:0]  = q_r.tdiv;
				sps_pkg::OFS_REPEAT: q_nxt.prdata[27:0]  = q_r.rep;
				sps_pkg::OFS_STATUS: begin
					q_nxt.prdata[3:0] = q_r.st;
					q_nxt.prdata[sps_pkg::ST_SRC_POS +: 2]  = q_r.src;
					q_nxt.prdata[sps_pkg::ST_PPB_POS +: 2]  = q_r.ppb;
					q_nxt.prdata[sps_pkg::ST_STEP_POS +: 10] = q_r.step;
					q_nxt.prdata[sps_pkg::ST_SONG_POS +: 4] = q_r.song;
					q_nxt.prdata[sps_pkg::ST_RUN_POS]       = (q_r.st == sps_pkg::ST_PLAY);
				end
				default: q_nxt.pslverr = 1'b1;
			endcase
		end else begin
			// error drops together with ready
			q_nxt.pslverr = 1'b0;
		end
		if (psel_in && penable_in && q_r.pready && pwrite_in) begin
			case (a)
				sps_pkg::OFS_CTRL:   q_nxt.busy = pwdata_in[0];
				sps_pkg::OFS_LAST:   q_nxt.last = (pwdata_in[9:0] == 10'd0) ? 10'd1
				                                                           : pwdata_in[9:0];
				sps_pkg::OFS_PLEN:   q_nxt.plen = (pwdata_in[15:0] == 16'd0) ? 16'd1
				                                                            : pwdata_in[15:0];
				sps_pkg::OFS_TDIV:   q_nxt.tdiv = (pwdata_in[19:0] == 20'd0) ? 20'd1
				                                                            : pwdata_in[19:0];
				sps_pkg::OFS_REPEAT: q_nxt.rep  = pwdata_in[27:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			q_r      <= '0;
			q_r.st   <= sps_pkg::ST_SONG_SEL;
			q_r.step <= 10'd1;
			q_r.last <= sps_pkg::LAST_RST;
			q_r.plen <= sps_pkg::PLEN_RST;
			q_r.tdiv <= sps_pkg::TDIV_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from the state register
	// ----------------------------------------------------------------
	assign prdata_out        = q_r.prdata;
	assign pready_out        = q_r.pready;
	assign pslverr_out       = q_r.pslverr;
	assign tape_out          = q_r.tape_o;
	assign run_lamp_out      = q_r.lamp;
	assign tape_xfer_en_out  = q_r.xfer;
	assign tape_fetch_out    = q_r.fetch_op;
	assign tape_store_en_out = q_r.store;
	assign disp_state_out    = q_r.st;
	assign disp_song_out     = q_r.song;
	assign disp_step_out     = q_r.step;
	assign step_tick_out     = q_r.step_tick;
endmodule : sps_ctrl
`default_nettype wire

/* File: test/sps_ctrl_properties.sv */
// Purpose: port-level checks of the song playback / sync control block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   attached to every sps_ctrl instance by the bind below
`timescale 1ns/10ps
`default_nettype none
module sps_ctrl_properties #(
	parameter int END_CYC = sps_pkg::END_CYC
) (
	input wire logic       clk_in,
	input wire logic       sys_rst_in,
	input wire logic       psel_in,
	input wire logic       penable_in,
	input wire logic       pready_out,
	input wire logic       pslverr_out,
	input wire logic       run_lamp_out,
	input wire logic [3:0] disp_state_out,
	input wire logic [9:0] disp_step_out,
	input wire logic       tape_out,
	input wire logic       tape_xfer_en_out,
	input wire logic       tape_fetch_out,
	input wire logic       tape_store_en_out
);
	// ------------------------------------------------------------
	// helper logic
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);
	int end_cnt_r;
	// cycles spent on the song-end screen
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || disp_state_out != 4'h4)
			end_cnt_r <= 0;
		else
			end_cnt_r <= end_cnt_r + 1;
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	lamp_tracks_play_a: assert property (run_lamp_out == (disp_state_out == 4'h2))
		else $error("run lamp disagrees with play state");
	step_above_zero_a: assert property (disp_step_out != 10'h000)
		else $error("step number fell to zero");
	end_screen_time_a: assert property (end_cnt_r <= END_CYC)
		else $error("song-end screen held too long");
	apb_answer_a: assert property (psel_in && !penable_in |=> pready_out)
		else $error("no ready in access cycle");
	ready_one_cycle_a: assert property (pready_out |=> !pready_out)
		else $error("ready held over two cycles");
	error_with_ready_a: assert property (pslverr_out |-> pready_out)
		else $error("slave error without ready");
	xfer_only_state_a: assert property (tape_xfer_en_out == (disp_state_out == 4'h8))
		else $error("tape transfer outside transfer state");
	store_needs_fetch_a: assert property (tape_store_en_out |-> tape_xfer_en_out && tape_fetch_out)
		else $error("tape store enabled out of fetch");
	quiet_in_xfer_a: assert property (tape_xfer_en_out && $past(tape_xfer_en_out) |-> !tape_out)
		else $error("pulse clock on tape output during transfer");
endmodule : sps_ctrl_properties
bind sps_ctrl sps_ctrl_properties #(.END_CYC(END_CYC)) sps_ctrl_properties_inst (
	.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
	.pready_out(pready_out), .pslverr_out(pslverr_out), .run_lamp_out(run_lamp_out),
	.disp_state_out(disp_state_out), .disp_step_out(disp_step_out), .tape_out(tape_out),
	.tape_xfer_en_out(tape_xfer_en_out), .tape_fetch_out(tape_fetch_out),
	.tape_store_en_out(tape_store_en_out));
`default_nettype wire

/* File: test/sps_ext_src.sv */
// Purpose: stand-in for the far-side clock sources, midi sequencer and pulse box
// Assumes: 80 ns link period, unrelated in phase to the system clock
// Notes:   lines rest low while disabled, like an idle gate output
`timescale 1ns/10ps
`default_nettype none
module sps_ext_src (
	input  wire logic midi_en_in,
	input  wire logic pulse_en_in,
	output var logic  midi_tick_out,
	output var logic  tape_pulse_out
);
	// ------------------------------------------------------------
	// pulse trains
	// ------------------------------------------------------------
	// far side supplies clock
	initial begin
		midi_tick_out  = 1'b0;
		tape_pulse_out = 1'b0;
		#3.3;
		forever begin
			#40;
			midi_tick_out  = midi_en_in & ~midi_tick_out;
			tape_pulse_out = pulse_en_in & ~tape_pulse_out;
		end
	end
endmodule : sps_ext_src
`default_nettype wire

/* File: test/song_playback_sync_control_tb_top.sv */
// Purpose: self-checking bench of the song playback / sync control block
// Assumes: short end/hold/repeat counts, fast local tick set over apb
// Notes:   all panel state is checked through the read-only status word
`timescale 1ns/10ps
`default_nettype none
module song_playback_sync_control_tb_top;
	logic        clk_in = 0, sys_rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
	logic [7:0]  paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0, prdata_out;
	logic        pready_out, pslverr_out, tape_in, midi_tick_in, midi_en = 0, pulse_en = 0;
	logic [10:0] keys_in = 11'h000;
	logic [3:0]  digit_in = 4'h0;
	logic [32:0] exp_q[$], msk_q[$];
	int          error_cnt = 0, checked = 0, seed = 45, n;
	logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
	logic [32:0] rv[6] = '{33'h0, 33'h10, 33'h180, 33'h9EF21, 33'h0, 33'h1_0000_0000};
	localparam logic [32:0] ME = 33'h1_0000_0000; // error flag only
	// free-running system clock
	always #4 clk_in = ~clk_in;
	sps_ctrl #(.END_CYC(50), .HOLD_CYC(20), .RPT_CYC(5)) sps_ctrl_inst (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
		.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.keys_in(keys_in), .digit_in(digit_in), .tape_in(tape_in), .midi_tick_in(midi_tick_in),
		.tape_out(), .tape_xfer_en_out(), .tape_fetch_out(), .tape_store_en_out(),
		.run_lamp_out(), .disp_state_out(), .disp_song_out(), .disp_step_out(),
		.step_tick_out());
	sps_ext_src sps_ext_src_inst (.midi_en_in(midi_en), .pulse_en_in(pulse_en),
		.midi_tick_out(midi_tick_in), .tape_pulse_out(tape_in));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [32:0] e, input logic [32:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		@(posedge clk_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= w;
		paddr_in   <= a;
		pwdata_in  <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb
	task automatic st(input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, 8'h14, 32'h0, {1'b0, e}, {1'b1, m});
	endtask : st
	task automatic ck(input logic [3:0] s);
		st({28'h0, s}, 32'hF);
	endtask : ck
	task automatic sp(input logic [3:0] s, input logic [9:0] p);
		st({9'h0, s == 4'h2, 4'h0, p, 4'h0, s}, 32'h0043FF0F);
	endtask : sp
	// key pins stay up len cycles; secondary raised before them, dropped with them
	task automatic press(input int k, input logic sec, input int len = 6);
		@(posedge clk_in);
		keys_in[7] <= sec;
		repeat (3) @(posedge clk_in);
		keys_in[k] <= 1'b1;
		repeat (len) @(posedge clk_in);
		keys_in <= 11'h000;
		repeat (8) @(posedge clk_in);
	endtask : press
	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done
	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// oldest note against each finished transfer
	always @(posedge clk_in) begin
		if (psel_in && penable_in && pready_out === 1'b1 && exp_q.size() > 0) begin
			checked++;
			if (({pslverr_out, prdata_out} & msk_q[0]) !== exp_q[0]) begin
				error_cnt++;
				$display("mismatch at %0t: got %h expected %h", $time,
					{pslverr_out, prdata_out} & msk_q[0], exp_q[0]);
			end
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end
	// watchdog, far beyond the expected run
	initial begin
		#300000;
		error_cnt++;
		end_sim();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		repeat (6) @(posedge clk_in);
		for (int i = 0; i < 6; i++) apb(1'b0, ra[i], 32'h0, rv[i], {33{1'b1}});
		apb(1'b1, 8'h14, 32'hFFFFFFFF, 33'h0, ME);
		apb(1'b1, 8'h18, 32'h0, ME, ME);
		apb(1'b1, 8'h04, 32'h3, 33'h0, ME);
		apb(1'b1, 8'h08, 32'h4, 33'h0, ME);
		apb(1'b1, 8'h0C, 32'h14, 33'h0, ME);
		sp(4'h0, 10'h1);
		done("registers");
		press(sps_pkg::K_START, 0);
		sp(4'h2, 10'h1);
		press(sps_pkg::K_HALT, 0);
		repeat (300) @(posedge clk_in);
		sp(4'h3, 10'h1);
		n = $unsigned($random(seed)) % 5;
		repeat (n) press(sps_pkg::K_INC, 0);
		sp(4'h3, (n > 1) ? 10'h3 : 10'(n + 1));
		press(sps_pkg::K_INC, 0, 60);
		sp(4'h3, 10'h3);
		press(sps_pkg::K_DEC, 0, 60);
		sp(4'h3, 10'h1);
		press(sps_pkg::K_INC, 0);
		press(sps_pkg::K_HALT, 0);
		sp(4'h2, 10'h2);
		press(sps_pkg::K_HALT, 0);
		press(sps_pkg::K_START, 0);
		sp(4'h2, 10'h1);
		repeat (400) @(posedge clk_in);
		ck(4'h0);
		done("playback");
		press(sps_pkg::K_START, 0);
		press(sps_pkg::K_HALT, 0);
		press(sps_pkg::K_LIB, 0);
		ck(4'h0);
		press(sps_pkg::K_START, 0);
		press(sps_pkg::K_HALT, 0);
		digit_in <= 4'h5;
		press(sps_pkg::K_NUM, 0);
		st({10'h0, 4'h5, 18'h0}, 32'h003C000F);
		done("leave halt");
		press(sps_pkg::K_TAPE, 0);
		ck(4'h0);
		press(sps_pkg::K_TAPE, 1);
		ck(4'h7);
		press(sps_pkg::K_STORE, 0);
		ck(4'h8);
		press(sps_pkg::K_TAPE, 0);
		press(sps_pkg::K_FETCH, 0);
		ck(4'h8);
		press(sps_pkg::K_TAPE, 0);
		press(sps_pkg::K_DEC, 0);
		ck(4'h0);
		press(sps_pkg::K_TAPE, 1);
		press(sps_pkg::K_TAPE, 0);
		ck(4'h0);
		done("tape menu");
		press(sps_pkg::K_SYNC, 1);
		ck(4'h5);
		repeat (3) press(sps_pkg::K_DEC, 0);
		press(sps_pkg::K_INC, 0);
		st(32'h0, 32'h3F);
		apb(1'b1, 8'h00, 32'h1, 33'h0, ME);
		press(sps_pkg::K_SYNC, 1);
		press(sps_pkg::K_DEC, 0);
		press(sps_pkg::K_INC, 0);
		ck(4'h5);
		apb(1'b1, 8'h00, 32'h0, 33'h0, ME);
		press(sps_pkg::K_INC, 0);
		ck(4'h6);
		repeat (2) press(sps_pkg::K_INC, 0);
		press(sps_pkg::K_SYNC, 0);
		st(32'h90, 32'hFF);
		press(sps_pkg::K_START, 0);
		repeat (300) @(posedge clk_in);
		sp(4'h2, 10'h1);
		pulse_en <= 1'b1;
		repeat (400) @(posedge clk_in);
		pulse_en <= 1'b0;
		ck(4'h0);
		press(sps_pkg::K_SYNC, 1);
		press(sps_pkg::K_DEC, 0);
		press(sps_pkg::K_INC, 0);
		st(32'h20, 32'h3F);
		press(sps_pkg::K_START, 0);
		repeat (300) @(posedge clk_in);
		sp(4'h2, 10'h1);
		midi_en <= 1'b1;
		repeat (400) @(posedge clk_in);
		midi_en <= 1'b0;
		ck(4'h0);
		done("sync source");
		end_sim();
	end
endmodule : song_playback_sync_control_tb_top
`default_nettype wire
